// >>> verilog/cpu_regs_pkg.sv
// shared constants, field layouts and carrier types of the cpu register set
package cpu_regs_pkg;

  // widths
  localparam int WORD_W   = 16;               // data, pointer, base words
  localparam int LONG_W   = 32;               // concatenated pairs
  localparam int ADDR_W   = 20;               // program counter, vector base
  localparam int FLAG_W   = 11;               // status word width
  localparam int SEL_W    = 4;                // register index width
  localparam int BUS_D_W  = 32;               // register port data width
  localparam int BANKS    = 2;                // banked copies
  localparam int BANK_REGS = 7;               // words per bank

  // register indices, shared by the register port and the datapath
  localparam logic [SEL_W-1:0] IDX_DATA0  = 4'h0;  // data_word_zero
  localparam logic [SEL_W-1:0] IDX_DATA1  = 4'h1;  // data_word_one
  localparam logic [SEL_W-1:0] IDX_DATA2  = 4'h2;  // data_word_two
  localparam logic [SEL_W-1:0] IDX_DATA3  = 4'h3;  // data_word_three
  localparam logic [SEL_W-1:0] IDX_PTR0   = 4'h4;  // pointer_word_zero
  localparam logic [SEL_W-1:0] IDX_PTR1   = 4'h5;  // pointer_word_one
  localparam logic [SEL_W-1:0] IDX_FRAME  = 4'h6;  // frame_base
  localparam logic [SEL_W-1:0] IDX_VECT   = 4'h7;  // vector_table_base
  localparam logic [SEL_W-1:0] IDX_PC     = 4'h8;  // next_instruction_pointer
  localparam logic [SEL_W-1:0] IDX_USP    = 4'h9;  // user_stack_pointer
  localparam logic [SEL_W-1:0] IDX_ISP    = 4'hA;  // interrupt_stack_pointer
  localparam logic [SEL_W-1:0] IDX_STATIC = 4'hB;  // static_base
  localparam logic [SEL_W-1:0] IDX_STATUS = 4'hC;  // cpu_status_word
  localparam logic [SEL_W-1:0] IDX_ACTSP  = 4'hD;  // active stack pointer view

  // status word field positions
  localparam int FLG_CARRY  = 0;
  localparam int FLG_DEBUG  = 1;
  localparam int FLG_ZERO   = 2;
  localparam int FLG_SIGN   = 3;
  localparam int FLG_BANK   = 4;
  localparam int FLG_OVFL   = 5;
  localparam int FLG_INTEN  = 6;
  localparam int FLG_STACK  = 7;
  localparam int FLG_PRIO_LO = 8;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [FLAG_W-1:0] FLAG_RST = 11'h000;
  localparam logic [LONG_W-1:0] LONG_RST = 32'h00000000;

  // access width of a datapath transfer
  typedef enum logic [1:0] {
    ACC_BYTE_LO = 2'b00,
    ACC_BYTE_HI = 2'b01,
    ACC_WORD    = 2'b11,
    ACC_LONG    = 2'b10
  } acc_width_e;

  // datapath write request
  typedef struct packed {
    logic                 en;
    logic [SEL_W-1:0]     sel;
    acc_width_e           width;
    logic [LONG_W-1:0]    data;
  } dp_write_s;

  // alu result for flag update
  typedef struct packed {
    logic                 updCarry;
    logic                 updZero;
    logic                 updSign;
    logic                 updOvfl;
    logic                 byteOp;
    logic [WORD_W-1:0]    result;
    logic                 carry;
    logic                 ovfl;
  } alu_flags_s;

  // datapath read request
  typedef struct packed {
    logic [SEL_W-1:0]     sel;
    logic                 long;
  } dp_read_s;

endpackage

// >>> verilog/cpu_register_set.sv
// architectural register set: two banks, shared pointers, status word
`timescale 1ns/10ps
`default_nettype none

module cpu_register_set #(
  parameter int PC_STEP_W = 3                     // instruction length field
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // register port
  input  wire logic [cpu_regs_pkg::SEL_W-1:0]      regAddr,
  input  wire logic [cpu_regs_pkg::BUS_D_W-1:0]    regWdata,
  input  wire logic                                regWr,
  input  wire logic                                regRd,
  output logic      [cpu_regs_pkg::BUS_D_W-1:0]    regRdata_ff,
  // datapath side
  input  wire cpu_regs_pkg::dp_write_s             dpWrite,
  input  wire cpu_regs_pkg::alu_flags_s            aluFlags,
  input  wire logic                                pcAdvance,
  input  wire logic [PC_STEP_W-1:0]                pcStep,
  input  wire cpu_regs_pkg::dp_read_s              dpReadA,
  input  wire cpu_regs_pkg::dp_read_s              dpReadB,
  output logic      [cpu_regs_pkg::LONG_W-1:0]     rdDataA_ff,
  output logic      [cpu_regs_pkg::LONG_W-1:0]     rdDataB_ff,
  output logic      [cpu_regs_pkg::ADDR_W-1:0]     pc_ff,
  output logic      [cpu_regs_pkg::ADDR_W-1:0]     vectBase_ff,
  output logic      [cpu_regs_pkg::WORD_W-1:0]     staticBase_ff,
  output logic      [cpu_regs_pkg::WORD_W-1:0]     activeSp_ff,
  output logic      [cpu_regs_pkg::FLAG_W-1:0]     status_ff
);

  // short names for package widths
  localparam int WW = cpu_regs_pkg::WORD_W;
  localparam int AW = cpu_regs_pkg::ADDR_W;
  localparam int FW = cpu_regs_pkg::FLAG_W;
  localparam int LW = cpu_regs_pkg::LONG_W;
  localparam int SW = cpu_regs_pkg::SEL_W;
  localparam int NB = cpu_regs_pkg::BANKS;
  localparam int NR = cpu_regs_pkg::BANK_REGS;

  // banked storage: data 0..3, pointer 0..1, frame base per bank
  // pointers and frame base share the data path
  logic [WW-1:0] bank_ff     [NB][NR];
  logic [WW-1:0] nxt_bank    [NB][NR];

  // shared registers
  logic [WW-1:0] usp_ff;                          // user stack
  logic [WW-1:0] isp_ff;                          // interrupt stack
  // next values of shared registers
  logic [AW-1:0] nxt_pc;
  logic [AW-1:0] nxt_vect;
  logic [WW-1:0] nxt_static;
  logic [WW-1:0] nxt_usp;
  logic [WW-1:0] nxt_isp;
  logic [FW-1:0] nxt_status;
  logic [WW-1:0] nxt_activeSp;

  // merge a byte or word into an existing word
  function automatic logic [WW-1:0] mergeWord(
    input logic [WW-1:0]               old,
    input logic [WW-1:0]               val,
    input cpu_regs_pkg::acc_width_e    width
  );
    logic [WW-1:0] res;
    res = val;
    // word and long take the low word
    case (width)
      // a byte keeps the other half
      cpu_regs_pkg::ACC_BYTE_LO: res = {old[WW-1:8], val[7:0]};
      cpu_regs_pkg::ACC_BYTE_HI: res = {val[7:0], old[7:0]};
      default:                   res = val;
    endcase
    return res;
  endfunction

  // index of the upper word of a long pair, or same index if none
  function automatic logic [SW-1:0] longHiIdx(input logic [SW-1:0] sel);
    logic [SW-1:0] res;
    res = sel;
    case (sel)
      cpu_regs_pkg::IDX_DATA0: res = cpu_regs_pkg::IDX_DATA2;
      cpu_regs_pkg::IDX_DATA1: res = cpu_regs_pkg::IDX_DATA3;
      cpu_regs_pkg::IDX_PTR0:  res = cpu_regs_pkg::IDX_PTR1;
      // no partner word elsewhere
      default:                 res = sel;
    endcase
    return res;
  endfunction

  // true where a long pair starts
  function automatic logic isLongBase(input logic [SW-1:0] sel);
    // data zero, data one, pointer zero
    return (sel == cpu_regs_pkg::IDX_DATA0) ||
           (sel == cpu_regs_pkg::IDX_DATA1) ||
           (sel == cpu_regs_pkg::IDX_PTR0);
  endfunction

  // word view of any register through the current bank
  function automatic logic [LW-1:0] wordView(
    input logic [SW-1:0] sel,
    input logic          bankSel
  );
    logic [LW-1:0] res;
    // unmapped indices stay zero
    res = cpu_regs_pkg::LONG_RST;
    case (sel)
      // shared: same in either bank
      cpu_regs_pkg::IDX_VECT:   res = {12'h000, vectBase_ff};
      cpu_regs_pkg::IDX_PC:     res = {12'h000, pc_ff};
      cpu_regs_pkg::IDX_USP:    res = {16'h0000, usp_ff};
      cpu_regs_pkg::IDX_ISP:    res = {16'h0000, isp_ff};
      cpu_regs_pkg::IDX_STATIC: res = {16'h0000, staticBase_ff};
      cpu_regs_pkg::IDX_STATUS: res = {21'h0, status_ff};
      cpu_regs_pkg::IDX_ACTSP:  res = {16'h0000, activeSp_ff};
      default: begin
        // banked words, routed by the bank flag
        if (sel < SW'(NR)) begin
          res = {16'h0000, bank_ff[bankSel][sel[2:0]]};
        end
      end
    endcase
    return res;
  endfunction

  // a bank switch applies next cycle
  // current selections from the status word
  wire           curBank  = status_ff[cpu_regs_pkg::FLG_BANK];
  wire           curStack = status_ff[cpu_regs_pkg::FLG_STACK];

  // register port decode
  // the port never stalls a strobe
  wire           busWr     = regWr;
  wire           busBankWr = busWr && (regAddr < SW'(NR));
  wire [2:0]     busBankIx = regAddr[2:0];
  wire [WW-1:0]  busWord   = regWdata[WW-1:0];

  // datapath decode
  wire           dpEn      = dpWrite.en;
  wire [SW-1:0]  dpSel     = dpWrite.sel;
  wire           dpLong    = dpWrite.width == cpu_regs_pkg::ACC_LONG;
  wire           dpByte    = (dpWrite.width == cpu_regs_pkg::ACC_BYTE_LO) ||
                             (dpWrite.width == cpu_regs_pkg::ACC_BYTE_HI);
  // bytes only exist for data words zero and one
  wire           byteOk    = (dpSel == cpu_regs_pkg::IDX_DATA0) ||
                             (dpSel == cpu_regs_pkg::IDX_DATA1);
  wire           dpLongOk  = dpLong && isLongBase(dpSel);
  // refused: byte on other words, long on a banked word without a pair
  wire           dpOk      = dpEn && (!dpByte || byteOk) &&
                             (!dpLong || dpLongOk || (dpSel >= SW'(NR)));
  // refused writes change nothing
  wire           dpBankWr  = dpOk && (dpSel < SW'(NR));
  wire [2:0]     dpBankIx  = dpSel[2:0];
  // partner of a long, full index
  wire [SW-1:0]  dpHiSel   = longHiIdx(dpSel);
  wire [2:0]     dpHiIx    = dpHiSel[2:0];
  // low and high halves of the data
  wire [WW-1:0]  dpLoWord  = dpWrite.data[WW-1:0];
  wire [WW-1:0]  dpHiWord  = dpWrite.data[LW-1:WW];

  // per-target write hits, datapath after register port
  // all inputs are arguments, so assigns re-evaluate
  function automatic logic hit(
    input logic          ok,
    input logic [SW-1:0] sel,
    input logic [SW-1:0] idx
  );
    return ok && (sel == idx);
  endfunction

  // port hits on shared registers
  wire           busHitPc  = busWr && (regAddr == cpu_regs_pkg::IDX_PC);
  wire           busHitVec = busWr && (regAddr == cpu_regs_pkg::IDX_VECT);
  wire           busHitSb  = busWr && (regAddr == cpu_regs_pkg::IDX_STATIC);
  wire           busHitFlg = busWr && (regAddr == cpu_regs_pkg::IDX_STATUS);
  wire           busHitAct = busWr && (regAddr == cpu_regs_pkg::IDX_ACTSP);
  wire           busHitUsp = busWr && ((regAddr == cpu_regs_pkg::IDX_USP) ||
                             (busHitAct && curStack));
  wire           busHitIsp = busWr && ((regAddr == cpu_regs_pkg::IDX_ISP) ||
                             (busHitAct && !curStack));

  // datapath hits on the stack pointers
  wire           dpHitAct  = hit(dpOk, dpSel, cpu_regs_pkg::IDX_ACTSP);
  wire           dpHitUsp  = hit(dpOk, dpSel, cpu_regs_pkg::IDX_USP) ||
                             (dpHitAct && curStack);
  wire           dpHitIsp  = hit(dpOk, dpSel, cpu_regs_pkg::IDX_ISP) ||
                             (dpHitAct && !curStack);

  // next banked contents; only the selected bank is touched
  always_comb begin
    nxt_bank = bank_ff;
    // port first, datapath overrides
    if (busBankWr) begin
      nxt_bank[curBank][busBankIx] = busWord;
    end
    if (dpBankWr) begin
      nxt_bank[curBank][dpBankIx] =
        mergeWord(bank_ff[curBank][dpBankIx], dpLoWord, dpWrite.width);
      if (dpLongOk) begin
        // upper half of a pair goes to its partner word
        nxt_bank[curBank][dpHiIx] = dpHiWord;
      end
    end
  end

  // program counter: writes win over sequential advance
  // a step wraps at the top
  assign nxt_pc = hit(dpOk, dpSel, cpu_regs_pkg::IDX_PC) ?
                  dpWrite.data[AW-1:0] :
                  busHitPc  ? regWdata[AW-1:0] :
                  pcAdvance ? pc_ff + AW'(pcStep) :
                  pc_ff;

  // vector table base and static base
  assign nxt_vect   = hit(dpOk, dpSel, cpu_regs_pkg::IDX_VECT) ?
                      dpWrite.data[AW-1:0] :
                      busHitVec ? regWdata[AW-1:0] : vectBase_ff;
  assign nxt_static = hit(dpOk, dpSel, cpu_regs_pkg::IDX_STATIC) ?
                      dpLoWord :
                      busHitSb ? busWord : staticBase_ff;

  // stack pointers; the active view writes whichever one is chosen
  // datapath wins over the port
  assign nxt_usp = dpHitUsp ? dpLoWord : busHitUsp ? busWord : usp_ff;
  assign nxt_isp = dpHitIsp ? dpLoWord : busHitIsp ? busWord : isp_ff;

  // alu-derived flags; byte results look at the low byte only
  wire [WW-1:0]  aluRes   = aluFlags.result;
  wire           resZero  = aluFlags.byteOp ? (aluRes[7:0] == 8'h00) :
                                              (aluRes == 16'h0000);
  wire           resNeg   = aluFlags.byteOp ? aluRes[7] : aluRes[WW-1];

  // status word: register port, then datapath, then alu result bits
  always_comb begin
    nxt_status = status_ff;
    // whole-word writes first
    if (busHitFlg) begin
      // debug bit is stored as written, software keeps it clear
      nxt_status = regWdata[FW-1:0];
    end
    if (hit(dpOk, dpSel, cpu_regs_pkg::IDX_STATUS)) begin
      nxt_status = dpWrite.data[FW-1:0];
    end
    // alu flags last, so they win
    if (aluFlags.updCarry) begin
      nxt_status[cpu_regs_pkg::FLG_CARRY] = aluFlags.carry;
    end
    if (aluFlags.updZero) begin
      nxt_status[cpu_regs_pkg::FLG_ZERO] = resZero;
    end
    if (aluFlags.updSign) begin
      nxt_status[cpu_regs_pkg::FLG_SIGN] = resNeg;
    end
    if (aluFlags.updOvfl) begin
      nxt_status[cpu_regs_pkg::FLG_OVFL] = aluFlags.ovfl;
    end
  end

  // active stack pointer follows the stack flag as it will stand
  // no mux after the flop
  assign nxt_activeSp = nxt_status[cpu_regs_pkg::FLG_STACK] ?
                        nxt_usp : nxt_isp;

  // read views: long pairs glue the partner word on top
  logic [LW-1:0] viewA;
  logic [LW-1:0] viewAHi;
  logic [LW-1:0] viewB;
  logic [LW-1:0] viewBHi;
  logic [LW-1:0] busView;

  // wordView reads registers directly; an assign
  // would miss their changes, a process does not
  always_comb begin
    viewA   = wordView(dpReadA.sel, curBank);
    viewAHi = wordView(longHiIdx(dpReadA.sel), curBank);
    viewB   = wordView(dpReadB.sel, curBank);
    viewBHi = wordView(longHiIdx(dpReadB.sel), curBank);
    // unmapped indices read as zero through wordView
    busView = wordView(regAddr, curBank);
  end

  wire [LW-1:0]  readA    = (dpReadA.long && isLongBase(dpReadA.sel)) ?
                            {viewAHi[WW-1:0], viewA[WW-1:0]} : viewA;
  wire [LW-1:0]  readB    = (dpReadB.long && isLongBase(dpReadB.sel)) ?
                            {viewBHi[WW-1:0], viewB[WW-1:0]} : viewB;

  // banked storage; reset clears both banks
  always_ff @(posedge clk) begin
    // both banks clear together
    for (int b = 0; b < NB; b++) begin
      for (int r = 0; r < NR; r++) begin
        bank_ff[b][r] <= !rst_n ? cpu_regs_pkg::WORD_RST : nxt_bank[b][r];
      end
    end
  end

  // shared address registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // constants only under reset
      pc_ff         <= cpu_regs_pkg::ADDR_RST;
      vectBase_ff   <= cpu_regs_pkg::ADDR_RST;
      staticBase_ff <= cpu_regs_pkg::WORD_RST;
    end else begin
      // reload every cycle
      pc_ff         <= nxt_pc;
      vectBase_ff   <= nxt_vect;
      staticBase_ff <= nxt_static;
    end
  end

  // stack pointers and their active copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // both pointers start at zero
      usp_ff      <= cpu_regs_pkg::WORD_RST;
      isp_ff      <= cpu_regs_pkg::WORD_RST;
      activeSp_ff <= cpu_regs_pkg::WORD_RST;
    end else begin
      // active copy tracks the flag
      usp_ff      <= nxt_usp;
      isp_ff      <= nxt_isp;
      activeSp_ff <= nxt_activeSp;
    end
  end

  // status word; a bank switch takes effect on the next cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // bank zero, interrupt stack
      status_ff <= cpu_regs_pkg::FLAG_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // registered read ports, answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // no stale data after reset
      rdDataA_ff  <= cpu_regs_pkg::LONG_RST;
      rdDataB_ff  <= cpu_regs_pkg::LONG_RST;
      regRdata_ff <= cpu_regs_pkg::LONG_RST;
    end else begin
      // datapath views every cycle
      rdDataA_ff  <= readA;
      rdDataB_ff  <= readB;
      // only a read strobe refreshes the port, otherwise zero
      regRdata_ff <= regRd ? busView : cpu_regs_pkg::LONG_RST;
    end
  end

endmodule

`default_nettype wire

// >>> bench/cpu_register_set_assertions.sv
// port checker for the cpu register set, bound at the foot of the file
`timescale 1ns/10ps
`default_nettype none
module cpu_register_set_assertions #(
  parameter int PC_STEP_W = 3  // instruction length field
) (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic [3:0]               regAddr,
  input wire logic [31:0]              regWdata,
  input wire logic                     regWr,
  input wire logic                     regRd,
  input wire logic [31:0]              regRdata_ff,
  input wire cpu_regs_pkg::dp_write_s  dpWrite,
  input wire cpu_regs_pkg::alu_flags_s aluFlags,
  input wire logic                     pcAdvance,
  input wire logic [PC_STEP_W-1:0]     pcStep,
  input wire cpu_regs_pkg::dp_read_s   dpReadA,
  input wire cpu_regs_pkg::dp_read_s   dpReadB,
  input wire logic [31:0]              rdDataA_ff,
  input wire logic [31:0]              rdDataB_ff,
  input wire logic [19:0]              pc_ff,
  input wire logic [19:0]              vectBase_ff,
  input wire logic [15:0]              staticBase_ff,
  input wire logic [15:0]              activeSp_ff,
  input wire logic [10:0]              status_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // one cycle clear of reset, so $past never looks into reset
  logic live_ff;
  always_ff @(posedge clk) live_ff <= rst_n;
  // decoded causes, named so $past sees a plain signal
  wire logic pcWr = (regWr && regAddr == 4'h8)
                    || (dpWrite.en && dpWrite.sel == 4'h8);
  wire logic vecLd = regWr && regAddr == 4'h7
                     && !(dpWrite.en && dpWrite.sel == 4'h7);
  wire logic sbLd = regWr && regAddr == 4'hB
                    && !(dpWrite.en && dpWrite.sel == 4'hB);
  wire logic rdPc = regRd && regAddr == 4'h8;
  wire logic rdHole = regRd && regAddr > 4'hD;
  wire logic zeroNow = aluFlags.byteOp ? aluFlags.result[7:0] == 8'h00
                                       : aluFlags.result == 16'h0000;
  wire logic signNow = aluFlags.byteOp ? aluFlags.result[7]
                                       : aluFlags.result[15];
  chk_pc_step: assert property (
    live_ff && $past(pcAdvance) && !$past(pcWr)
    |-> pc_ff == $past(pc_ff) + $past(pcStep))
    else $error("pc did not move by the step");
  chk_pc_hold: assert property (
    live_ff && !$past(pcAdvance) && !$past(pcWr) |-> $stable(pc_ff))
    else $error("pc moved without cause");
  chk_carry_flag: assert property (
    live_ff && $past(aluFlags.updCarry)
    |-> status_ff[0] == $past(aluFlags.carry))
    else $error("carry flag wrong");
  chk_zero_flag: assert property (
    live_ff && $past(aluFlags.updZero) |-> status_ff[2] == $past(zeroNow))
    else $error("zero flag wrong");
  chk_sign_flag: assert property (
    live_ff && $past(aluFlags.updSign) |-> status_ff[3] == $past(signNow))
    else $error("sign flag wrong");
  chk_ovfl_flag: assert property (
    live_ff && $past(aluFlags.updOvfl)
    |-> status_ff[5] == $past(aluFlags.ovfl))
    else $error("overflow flag wrong");
  chk_vect_load: assert property (
    live_ff && $past(vecLd) |-> vectBase_ff == $past(regWdata[19:0]))
    else $error("vector base not loaded");
  chk_static_load: assert property (
    live_ff && $past(sbLd) |-> staticBase_ff == $past(regWdata[15:0]))
    else $error("static base not loaded");
  chk_read_pc: assert property (
    live_ff && $past(rdPc) |-> regRdata_ff == {12'h000, $past(pc_ff)})
    else $error("pc read wrong");
  chk_read_hole: assert property (
    live_ff && $past(rdHole) |-> regRdata_ff == 32'h00000000)
    else $error("unmapped read not zero");
endmodule
bind cpu_register_set cpu_register_set_assertions #(
  .PC_STEP_W(PC_STEP_W)) u_chk (.clk, .rst_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata_ff, .dpWrite, .aluFlags, .pcAdvance, .pcStep, .dpReadA,
  .dpReadB, .rdDataA_ff, .rdDataB_ff, .pc_ff, .vectBase_ff, .staticBase_ff,
  .activeSp_ff, .status_ff);
`default_nettype wire

// >>> bench/alu_partner_model.sv
// alu stand-in: turns two operands into a flag update for the register set
`timescale 1ns/10ps
`default_nettype none
module alu_partner_model (
  input  wire logic                     go,
  input  wire logic                     byteOp,
  input  wire logic [15:0]              opA,
  input  wire logic [15:0]              opB,
  output var  cpu_regs_pkg::alu_flags_s flags
);
  wire logic [16:0] wSum = {1'b0, opA} + {1'b0, opB};  // word sum
  wire logic [8:0]  bSum = {1'b0, opA[7:0]} + {1'b0, opB[7:0]};  // byte
  // add only: carry and overflow come from the chosen width
  always_comb begin
    flags.updCarry = go;
    flags.updZero = go;
    flags.updSign = go;
    flags.updOvfl = go;
    flags.byteOp = byteOp;
    flags.result = byteOp ? {8'h00, bSum[7:0]} : wSum[15:0];
    flags.carry = byteOp ? bSum[8] : wSum[16];
    flags.ovfl = byteOp ? (opA[7] == opB[7] && bSum[7] != opA[7])
                        : (opA[15] == opB[15] && wSum[15] != opA[15]);
  end
endmodule
`default_nettype wire

// >>> bench/cpu_register_set_tb_top.sv
// self-checking bench: register set against an integer model
`timescale 1ns/10ps
`default_nettype none
module cpu_register_set_tb_top;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic [3:0]               regAddr = 4'h0;
  logic [31:0]              regWdata = 32'h00000000;
  logic                     regWr = 1'b0;
  logic                     regRd = 1'b0;
  logic                     pcAdvance = 1'b0;
  logic [2:0]               pcStep = 3'h0;
  logic                     go = 1'b0;      // partner: apply flags
  logic                     byteOp = 1'b0;  // partner: byte width
  logic [15:0]              opA = 16'h0000;
  logic [15:0]              opB = 16'h0000;
  cpu_regs_pkg::dp_write_s  dpWrite = '0;
  cpu_regs_pkg::dp_read_s   dpReadA = '0;
  cpu_regs_pkg::dp_read_s   dpReadB = '0;
  cpu_regs_pkg::alu_flags_s aluFlags;
  logic [31:0]              regRdata_ff, rdDataA_ff, rdDataB_ff;
  logic [19:0]              pc_ff, vectBase_ff;
  logic [15:0]              staticBase_ff, activeSp_ff;
  logic [10:0]              status_ff;
  int                       err_count = 0;
  int                       tests_run = 0;
  int                       bk[2][7];  // model banked words
  int                       sh[16];    // model shared words by index
  int                       sel[5] = '{0, 1, 2, 4, 11};  // datapath targets
  cpu_register_set #(.PC_STEP_W(3)) u_cpu_register_set (.clk, .rst_n,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata_ff, .dpWrite, .aluFlags,
    .pcAdvance, .pcStep, .dpReadA, .dpReadB, .rdDataA_ff, .rdDataB_ff,
    .pc_ff, .vectBase_ff, .staticBase_ff, .activeSp_ff, .status_ff);
  alu_partner_model u_alu_partner_model (.go, .byteOp, .opA, .opB,
    .flags(aluFlags));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic int bank();
    return (sh[12] >> 4) & 1;
  endfunction
  // model view of a port read
  function automatic int mrd(int i);
    if (i < 7) return bk[bank()][i];
    if (i < 13) return sh[i];
    if (i == 13) return sh[12][7] ? sh[9] : sh[10];
    return 0;  // unmapped reads as zero
  endfunction
  function automatic void mwr(int i, int v);
    if (i < 7) bk[bank()][i] = v & 'hFFFF;
    else if (i < 13)
      sh[i] = v & (i == 7 || i == 8 ? 'hFFFFF : i == 12 ? 'h7FF : 'hFFFF);
  endfunction
  // pair view on 0, 1 and 4, word view elsewhere
  function automatic int mlong(int s);
    if (s == 0 || s == 1 || s == 4)
      return bk[bank()][s] | bk[bank()][s + (s == 4 ? 1 : 2)] << 16;
    return mrd(s);
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one port write, then an idle edge so strobes never collide
  task automatic bw(int a, int d);
    regAddr <= a[3:0];
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
    mwr(a, d);
  endtask
  // port read: data stand only in the cycle after the strobe
  task automatic rdc(int a);
    regAddr <= a[3:0];
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata_ff, mrd(a));
    @(posedge clk);
  endtask
  task automatic dw(int s, cpu_regs_pkg::acc_width_e w, int d);
    int b;
    dpWrite <= {1'b1, s[3:0], w, d};
    @(posedge clk);
    dpWrite.en <= 1'b0;
    @(posedge clk);
    b = bank();
    if (w == cpu_regs_pkg::ACC_WORD || w == cpu_regs_pkg::ACC_LONG && s > 6)
      mwr(s, d);
    else if (w != cpu_regs_pkg::ACC_LONG && s < 2)
      bk[b][s] = w == cpu_regs_pkg::ACC_BYTE_LO ? bk[b][s] & 'hFF00 | d & 'hFF
                 : bk[b][s] & 'hFF | (d & 'hFF) << 8;
    else if (w == cpu_regs_pkg::ACC_LONG && s != 2) begin
      bk[b][s] = d & 'hFFFF;
      bk[b][s + (s == 4 ? 1 : 2)] = d >> 16 & 'hFFFF;
    end
  endtask
  // both read ports at once, long and word views
  task automatic dr(int s);
    dpReadA <= {s[3:0], 1'b1};
    dpReadB <= {s[3:0], 1'b0};
    @(posedge clk);
    #1 check(rdDataA_ff, mlong(s));
    check(rdDataB_ff, mrd(s));
    @(posedge clk);
  endtask
  task automatic alu(int a, int b, bit bo);
    int n, m, s, r, sg, ov, z;
    opA <= a[15:0];
    opB <= b[15:0];
    byteOp <= bo;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    n = bo ? 8 : 16;
    m = (1 << n) - 1;
    s = (a & m) + (b & m);
    r = s & m;
    z = r == 0;
    sg = r >> (n - 1) & 1;
    ov = (a >> (n - 1) & 1) == (b >> (n - 1) & 1) && sg != (a >> (n - 1) & 1);
    sh[12] = sh[12] & ~'h2D | s >> n & 1 | z << 2 | sg << 3 | ov << 5;
    check(status_ff, sh[12]);
  endtask
  // main sequence
  initial begin
    int d;
    void'($urandom(48));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rdc(i);
    // debug bit kept clear on every status write
    for (int i = 0; i < 16; i++)
      if (i != 13) bw(i, i == 12 ? $urandom & ~32'h2 : $urandom);
    for (int i = 0; i < 16; i++) rdc(i);
    check(pc_ff, sh[8]);
    check(vectBase_ff, sh[7]);
    check(staticBase_ff, sh[11]);
    check(status_ff, sh[12]);
    // each bank filled on its own, then both revisited
    for (int b = 0; b < 2; b++) begin
      bw(12, sh[12] & ~'h10 | b << 4);
      for (int j = 0; j < 7; j++) bw(j, $urandom);
    end
    for (int b = 0; b < 2; b++) begin
      bw(12, sh[12] & ~'h10 | b << 4);
      for (int j = 0; j < 7; j++) rdc(j);
    end
    for (int s = 0; s < 2; s++) begin
      bw(12, sh[12] & ~'h80 | s << 7);
      rdc(13);
      check(activeSp_ff, mrd(13));
    end
    for (int k = 0; k < 20; k++) begin
      dw(sel[k / 4], cpu_regs_pkg::acc_width_e'(k % 4), $urandom);
      dr(sel[k / 4]);
    end
    // first few results are forced to zero
    for (int k = 0; k < 40; k++) begin
      d = $urandom & 'hFFFF;
      alu(d, k < 4 ? -d : $urandom, k[0]);
    end
    for (int k = 0; k < 24; k++) begin
      pcStep <= 3'($urandom);
      pcAdvance <= k[0] | k[1];
      @(posedge clk);
      if (pcAdvance) sh[8] = (sh[8] + pcStep) & 'hFFFFF;
      // idle edge: pc holds, so it is settled when looked at
      pcAdvance <= 1'b0;
      @(posedge clk);
      check(pc_ff, sh[8]);
    end
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
